/* verilog/pre_pkg.sv */
// package: constants shared by the encoder back end and its controller
// assumes a 50 MHz system clock and a 16-bit word register port
package pre_pkg;
  // data widths
  localparam int ANGLE_W = 20;
  localparam int TURN_W  = 24;
  localparam int VEL_W   = 20;
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 8;
  // device register offsets (word index)
  localparam logic [7:0] REG_CTRL     = 8'h03;
  localparam logic [7:0] REG_STAT     = 8'h04;
  localparam logic [7:0] REG_ANG_LO   = 8'h05;
  localparam logic [7:0] REG_ANG_HI   = 8'h06;
  localparam logic [7:0] REG_TURN_LO  = 8'h07;
  localparam logic [7:0] REG_TURN_HI  = 8'h08;
  localparam logic [7:0] REG_VEL_LO   = 8'h09;
  localparam logic [7:0] REG_VEL_HI   = 8'h0a;
  localparam logic [7:0] REG_KV       = 8'h0b;
  localparam logic [7:0] REG_KA       = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0d;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0e;
  // field positions
  localparam int CTRL_BYPASS_BIT = 15;
  localparam int CTRL_TRIG_BIT   = 13;
  localparam int CTRL_SKIP_BIT   = 12;
  localparam int STAT_OPEN_BIT   = 13;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_OPEN_BIT    = 1;
  localparam int IRQ_TURN_BIT    = 2;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] COEF_RST = 16'h0000;
  // coefficient fraction bits and filter shift
  localparam int KSHIFT = 16;
  localparam int LPF_SH = 2;
  // timing
  localparam int CLK_NS          = 20;
  localparam int TEST_TIME_NS    = 1000;
  localparam int TEST_CYC        = TEST_TIME_NS / CLK_NS;
  localparam int STARTUP_TIME_NS = 200;
  localparam int STARTUP_CYC     = STARTUP_TIME_NS / CLK_NS;
  localparam int WAKE_PERIOD_US  = 1000;
  localparam int WAKE_PERIOD_CYC = WAKE_PERIOD_US * 1000 / CLK_NS;
  localparam int WAKE_LEN_NS     = 400;
  localparam int WAKE_LEN_CYC    = WAKE_LEN_NS / CLK_NS;
  // controller software registers
  localparam logic [2:0] H_KV      = 3'h0;
  localparam logic [2:0] H_KA      = 3'h1;
  localparam logic [2:0] H_CTRL    = 3'h2;
  localparam logic [2:0] H_STAT    = 3'h3;
  localparam logic [2:0] H_ANG_LO  = 3'h4;
  localparam logic [2:0] H_ANG_HI  = 3'h5;
  localparam logic [2:0] H_TURN_LO = 3'h6;
  localparam logic [2:0] H_TURN_HI = 3'h7;
  // device states
  typedef enum logic [2:0] {
    DS_START = 3'b001,
    DS_IDLE  = 3'b010,
    DS_TEST  = 3'b100
  } pre_dev_state_type;
endpackage

/* verilog/pre_link_if.sv */
// interface: 16-bit register port between controller and back end
// assumes both ends share i_mclk; read data stands one cycle after rd
`timescale 1ns/1ps
interface pre_link_if;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic        irq;
  logic        fe_wake;
  modport dev_mp (input addr, wdata, wr, rd, fe_wake, output rdata, irq);
  modport host_mp (output addr, wdata, wr, rd, fe_wake, input rdata, irq);
endinterface

/* verilog/pre_dev.sv */
// back end: angle, turns, velocity words, coil test, extrapolation
// assumes samples arrive synchronous to i_mclk from the front end
//
// Behaviour
// - angle is 20-bit unsigned, 2^20 per turn
// - turns count is 24-bit signed
// - clockwise adds one, counterclockwise subtracts one
// - velocity is 20-bit signed, 2^29 per rev/us
// - open coil found sets status bit 13
// - writing trigger bit starts test at once when idle; ignored during the startup wait
// - trigger bit stays set until test ends
// - startup test runs unless skip bit set
// - extrapolated angle adds gain-weighted velocity, acceleration
// - bypass bit reports unextrapolated angle
// - firmware keeps bypass until coefficients are set
// - firmware sleeps front end, wakes it periodically
`timescale 1ns/1ps
module pre_dev #(
  parameter int NCOIL = 8
) (
  // clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_b,
  // front end samples
  input  wire logic               i_sample_vld,
  input  wire logic [19:0]        i_angle,
  input  wire logic signed [19:0] i_velocity,
  input  wire logic [NCOIL-1:0]   i_coil_open,
  // result words
  output logic [19:0]             o_angle,
  output logic [23:0]             o_turns,
  output logic [19:0]             o_velocity,
  // link to the controller
  pre_link_if.dev_mp              link
);
  pre_pkg::pre_dev_state_type state_ff, nxt_state;
  logic [15:0]         cnt_ff, nxt_cnt;
  logic                trig_ff, bypass_ff, skip_ff;
  logic                open_ff, acc_open_ff;
  logic                seen_ff;
  logic [19:0]         ang_ff, ang_lpf_ff, rep_ff;
  logic signed [19:0]  vel_ff, vel_lpf_ff, acc_lpf_ff;
  logic [23:0]         turn_ff;
  logic signed [15:0]  kv_ff, ka_ff;
  logic [2:0]          irq_stat_ff, irq_mask_ff;
  logic [15:0]         rdata_ff, rd_mux;

  // strobe decode
  wire take     = i_sample_vld & link.fe_wake;
  wire wr_ctrl  = link.wr & (link.addr == pre_pkg::REG_CTRL);
  wire wr_kv    = link.wr & (link.addr == pre_pkg::REG_KV);
  wire wr_ka    = link.wr & (link.addr == pre_pkg::REG_KA);
  wire wr_istat = link.wr & (link.addr == pre_pkg::REG_IRQ_STAT);
  wire wr_imask = link.wr & (link.addr == pre_pkg::REG_IRQ_MASK);

  // test sequencing
  wire start_done = (cnt_ff == 16'(pre_pkg::STARTUP_CYC - 1));
  wire test_done  = (cnt_ff == 16'(pre_pkg::TEST_CYC - 1));
  wire sw_start   = (state_ff == pre_pkg::DS_IDLE) & wr_ctrl
                    & link.wdata[pre_pkg::CTRL_TRIG_BIT];
  wire por_start  = (state_ff == pre_pkg::DS_START) & start_done
                    & ~skip_ff;
  wire test_start = sw_start | por_start;
  wire test_end   = (state_ff == pre_pkg::DS_TEST) & test_done;
  wire found_open = acc_open_ff | (|i_coil_open);

  // wrap detection on the top two angle bits
  wire wrap_cw  = seen_ff & (ang_ff[19:18] == 2'b11)
                  & (i_angle[19:18] == 2'b00);
  wire wrap_ccw = seen_ff & (ang_ff[19:18] == 2'b00)
                  & (i_angle[19:18] == 2'b11);
  wire turn_step = take & (wrap_cw | wrap_ccw);

  // filter updates; the angle delta wraps so the filter follows 0/max
  wire signed [19:0] ang_d  = i_angle - ang_lpf_ff;
  wire signed [20:0] vel_d  = 21'(i_velocity) - 21'(vel_lpf_ff);
  wire signed [20:0] acc_in = 21'(i_velocity) - 21'(vel_ff);
  wire signed [20:0] acc_d  = acc_in - 21'(acc_lpf_ff);

  // extrapolation terms, truncated to one revolution
  wire signed [35:0] kv_term = kv_ff * vel_lpf_ff;
  wire signed [35:0] ka_term = ka_ff * acc_lpf_ff;
  wire [19:0] ext_angle = ang_lpf_ff + kv_term[35:pre_pkg::KSHIFT]
                          + ka_term[35:pre_pkg::KSHIFT];

  // interrupt events: set wins over the write-one clear
  wire [2:0] irq_ev  = {turn_step, test_end & found_open, test_end};
  wire [2:0] irq_clr = wr_istat ? link.wdata[2:0] : 3'h0;

  // state machine next state and counter
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff + 16'h0001;
    case (state_ff)
      pre_pkg::DS_START:
      begin
        if (start_done)
        begin
          nxt_state = skip_ff ? pre_pkg::DS_IDLE : pre_pkg::DS_TEST;
          nxt_cnt   = 16'h0000;
        end
      end
      pre_pkg::DS_IDLE:
      begin
        nxt_cnt = 16'h0000;
        if (sw_start)
          nxt_state = pre_pkg::DS_TEST;
      end
      pre_pkg::DS_TEST:
      begin
        if (test_done)
        begin
          nxt_state = pre_pkg::DS_IDLE;
          nxt_cnt   = 16'h0000;
        end
      end
      default:
      begin
        nxt_state = pre_pkg::DS_IDLE;
        nxt_cnt   = 16'h0000;
      end
    endcase
  end

  // state, counter and the coil test result
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      state_ff    <= pre_pkg::DS_START;
      cnt_ff      <= 16'h0000;
      acc_open_ff <= 1'b0;
      open_ff     <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      acc_open_ff <= test_start ? 1'b0 :
                     (state_ff == pre_pkg::DS_TEST) ? found_open : acc_open_ff;
      if (test_end)
        open_ff <= found_open;
    end
  end

  // control bits; writes of zero to the trigger are ignored mid-test
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      trig_ff   <= pre_pkg::CTRL_RST[pre_pkg::CTRL_TRIG_BIT];
      bypass_ff <= pre_pkg::CTRL_RST[pre_pkg::CTRL_BYPASS_BIT];
      skip_ff   <= pre_pkg::CTRL_RST[pre_pkg::CTRL_SKIP_BIT];
    end
    else
    begin
      if (test_start)
        trig_ff <= 1'b1;
      else if (test_end)
        trig_ff <= 1'b0;
      if (wr_ctrl)
      begin
        bypass_ff <= link.wdata[pre_pkg::CTRL_BYPASS_BIT];
        skip_ff   <= link.wdata[pre_pkg::CTRL_SKIP_BIT];
      end
    end
  end

  // sample capture, turns and filters
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      seen_ff    <= 1'b0;
      ang_ff     <= 20'h00000;
      ang_lpf_ff <= 20'h00000;
      vel_ff     <= 20'sh00000;
      vel_lpf_ff <= 20'sh00000;
      acc_lpf_ff <= 20'sh00000;
      turn_ff    <= 24'h000000;
    end
    else if (take)
    begin
      seen_ff    <= 1'b1;
      ang_ff     <= i_angle;
      vel_ff     <= i_velocity;
      ang_lpf_ff <= ang_lpf_ff + 20'(ang_d >>> pre_pkg::LPF_SH);
      vel_lpf_ff <= vel_lpf_ff + 20'(vel_d >>> pre_pkg::LPF_SH);
      acc_lpf_ff <= acc_lpf_ff + 20'(acc_d >>> pre_pkg::LPF_SH);
      if (wrap_cw)
        turn_ff <= turn_ff + 24'h000001;
      else if (wrap_ccw)
        turn_ff <= turn_ff - 24'h000001;
    end
  end

  // reported angle, one cycle behind the filter state
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      rep_ff <= 20'h00000;
    else
      rep_ff <= bypass_ff ? ang_ff : ext_angle;
  end

  // coefficients and interrupt registers
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      kv_ff       <= pre_pkg::COEF_RST;
      ka_ff       <= pre_pkg::COEF_RST;
      irq_stat_ff <= 3'h0;
      irq_mask_ff <= 3'h0;
    end
    else
    begin
      if (wr_kv)
        kv_ff <= link.wdata;
      if (wr_ka)
        ka_ff <= link.wdata;
      if (wr_imask)
        irq_mask_ff <= link.wdata[2:0];
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_ev;
    end
  end

  // read decode; unmapped offsets read zero
  always_comb
  begin
    rd_mux = 16'h0000;
    if (link.addr == pre_pkg::REG_CTRL)
    begin
      rd_mux[pre_pkg::CTRL_BYPASS_BIT] = bypass_ff;
      rd_mux[pre_pkg::CTRL_TRIG_BIT]   = trig_ff;
      rd_mux[pre_pkg::CTRL_SKIP_BIT]   = skip_ff;
    end
    else if (link.addr == pre_pkg::REG_STAT)
    begin
      rd_mux[pre_pkg::STAT_OPEN_BIT] = open_ff;
      rd_mux[pre_pkg::STAT_BUSY_BIT] = (state_ff == pre_pkg::DS_TEST);
    end
    else if (link.addr == pre_pkg::REG_ANG_LO)
      rd_mux = rep_ff[15:0];
    else if (link.addr == pre_pkg::REG_ANG_HI)
      rd_mux = {12'h000, rep_ff[19:16]};
    else if (link.addr == pre_pkg::REG_TURN_LO)
      rd_mux = turn_ff[15:0];
    else if (link.addr == pre_pkg::REG_TURN_HI)
      rd_mux = {{8{turn_ff[23]}}, turn_ff[23:16]};
    else if (link.addr == pre_pkg::REG_VEL_LO)
      rd_mux = vel_ff[15:0];
    else if (link.addr == pre_pkg::REG_VEL_HI)
      rd_mux = {{12{vel_ff[19]}}, vel_ff[19:16]};
    else if (link.addr == pre_pkg::REG_KV)
      rd_mux = kv_ff;
    else if (link.addr == pre_pkg::REG_KA)
      rd_mux = ka_ff;
    else if (link.addr == pre_pkg::REG_IRQ_STAT)
      rd_mux = {13'h0000, irq_stat_ff};
    else if (link.addr == pre_pkg::REG_IRQ_MASK)
      rd_mux = {13'h0000, irq_mask_ff};
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      rdata_ff <= 16'h0000;
    else
      rdata_ff <= link.rd ? rd_mux : 16'h0000;
  end

  // outputs
  assign link.rdata = rdata_ff;
  assign link.irq   = |(irq_stat_ff & irq_mask_ff);
  assign o_angle    = rep_ff;
  assign o_turns    = turn_ff;
  assign o_velocity = vel_ff;
endmodule

/* verilog/pre_host.sv */
// controller end: relays software settings, polls the back end
// assumes back end answers reads one cycle after the strobe
`timescale 1ns/1ps
module pre_host #(
  parameter int WAKE_PERIOD = pre_pkg::WAKE_PERIOD_CYC
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_b,
  // software port
  input  wire logic [2:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [15:0]      o_rdata,
  // power mode and device interrupt
  input  wire logic        i_battery_mode,
  output logic             o_dev_irq,
  // link to the back end
  pre_link_if.host_mp      link
);
  logic [15:0] kv_ff, ka_ff, rdata_ff, ctrl_w;
  logic        kv_set_ff, ka_set_ff, ext_req_ff, skip_ff, pend_ff;
  logic        open_ff, busy_ff, wake_ff, cap_ff;
  logic [19:0] ang_ff;
  logic [23:0] turn_ff;
  logic [2:0]  job_ff;
  logic [7:0]  addr_ff, cap_addr_ff;
  logic [15:0] wdata_ff;
  logic        wr_ff, rd_ff;
  logic [31:0] wake_cnt_ff;
  logic [7:0]  job_addr;
  logic        job_wr;
  logic [15:0] job_data;
  logic [15:0] sw_mux;

  // extrapolation only once both coefficients were written
  wire coef_ok = kv_set_ff & ka_set_ff;
  // next awake level; strobes follow it so none lands in a sleep span
  wire nxt_wake = ~i_battery_mode
                  | (wake_cnt_ff < 32'(pre_pkg::WAKE_LEN_CYC));
  wire trig_go  = nxt_wake & (job_ff == 3'h2) & pend_ff;
  wire sw_run  = i_wr & (i_addr == pre_pkg::H_CTRL) & i_wdata[2];

  // control word sent to the back end
  always_comb
  begin
    ctrl_w = 16'h0000;
    ctrl_w[pre_pkg::CTRL_BYPASS_BIT] = ~(ext_req_ff & coef_ok);
    ctrl_w[pre_pkg::CTRL_SKIP_BIT]   = skip_ff;
    ctrl_w[pre_pkg::CTRL_TRIG_BIT]   = pend_ff;
  end

  // polling round: three writes then five reads
  always_comb
  begin
    job_wr   = 1'b0;
    job_data = 16'h0000;
    job_addr = pre_pkg::REG_STAT;
    case (job_ff)
      3'h0: begin job_wr = 1'b1; job_addr = pre_pkg::REG_KV;   job_data = kv_ff; end
      3'h1: begin job_wr = 1'b1; job_addr = pre_pkg::REG_KA;   job_data = ka_ff; end
      3'h2: begin job_wr = 1'b1; job_addr = pre_pkg::REG_CTRL; job_data = ctrl_w; end
      3'h3: job_addr = pre_pkg::REG_STAT;
      3'h4: job_addr = pre_pkg::REG_ANG_LO;
      3'h5: job_addr = pre_pkg::REG_ANG_HI;
      3'h6: job_addr = pre_pkg::REG_TURN_LO;
      default: job_addr = pre_pkg::REG_TURN_HI;
    endcase
  end

  // battery mode: front end asleep except a short window per period;
  // the count restarts on entry so the first window is never cut short
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      wake_cnt_ff <= 32'h00000000;
      wake_ff     <= 1'b1;
    end
    else
    begin
      wake_cnt_ff <= (!i_battery_mode || wake_cnt_ff >= 32'(WAKE_PERIOD - 1)) ? 32'h00000000
                     : wake_cnt_ff + 32'h00000001;
      wake_ff     <= nxt_wake;
    end
  end

  // link strobes registered; nothing is issued while asleep
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      job_ff      <= 3'h0;
      addr_ff     <= 8'h00;
      wdata_ff    <= 16'h0000;
      wr_ff       <= 1'b0;
      rd_ff       <= 1'b0;
      cap_ff      <= 1'b0;
      cap_addr_ff <= 8'h00;
    end
    else
    begin
      job_ff      <= nxt_wake ? job_ff + 3'h1 : 3'h0;
      addr_ff     <= job_addr;
      wdata_ff    <= job_data;
      wr_ff       <= nxt_wake & job_wr;
      rd_ff       <= nxt_wake & ~job_wr;
      cap_ff      <= rd_ff;
      cap_addr_ff <= addr_ff;
    end
  end

  // software settings; a new run request beats the issue clear
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      kv_ff      <= pre_pkg::COEF_RST;
      ka_ff      <= pre_pkg::COEF_RST;
      kv_set_ff  <= 1'b0;
      ka_set_ff  <= 1'b0;
      ext_req_ff <= 1'b0;
      skip_ff    <= 1'b0;
      pend_ff    <= 1'b0;
    end
    else
    begin
      if (i_wr && i_addr == pre_pkg::H_KV)
      begin
        kv_ff     <= i_wdata;
        kv_set_ff <= 1'b1;
      end
      if (i_wr && i_addr == pre_pkg::H_KA)
      begin
        ka_ff     <= i_wdata;
        ka_set_ff <= 1'b1;
      end
      if (i_wr && i_addr == pre_pkg::H_CTRL)
      begin
        ext_req_ff <= i_wdata[0];
        skip_ff    <= i_wdata[1];
      end
      pend_ff <= (pend_ff & ~trig_go) | sw_run;
    end
  end

  // capture read answers one cycle after each read strobe
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      open_ff <= 1'b0;
      busy_ff <= 1'b0;
      ang_ff  <= 20'h00000;
      turn_ff <= 24'h000000;
    end
    else if (cap_ff)
    begin
      if (cap_addr_ff == pre_pkg::REG_STAT)
      begin
        open_ff <= link.rdata[pre_pkg::STAT_OPEN_BIT];
        busy_ff <= link.rdata[pre_pkg::STAT_BUSY_BIT];
      end
      else if (cap_addr_ff == pre_pkg::REG_ANG_LO)
        ang_ff[15:0] <= link.rdata;
      else if (cap_addr_ff == pre_pkg::REG_ANG_HI)
        ang_ff[19:16] <= link.rdata[3:0];
      else if (cap_addr_ff == pre_pkg::REG_TURN_LO)
        turn_ff[15:0] <= link.rdata;
      else if (cap_addr_ff == pre_pkg::REG_TURN_HI)
        turn_ff[23:16] <= link.rdata[7:0];
    end
  end

  // software read decode
  always_comb
  begin
    sw_mux = 16'h0000;
    if (i_addr == pre_pkg::H_KV)
      sw_mux = kv_ff;
    else if (i_addr == pre_pkg::H_KA)
      sw_mux = ka_ff;
    else if (i_addr == pre_pkg::H_CTRL)
      sw_mux = {13'h0000, pend_ff, skip_ff, ext_req_ff};
    else if (i_addr == pre_pkg::H_STAT)
      sw_mux = {12'h000, ext_req_ff & coef_ok, coef_ok, busy_ff, open_ff};
    else if (i_addr == pre_pkg::H_ANG_LO)
      sw_mux = ang_ff[15:0];
    else if (i_addr == pre_pkg::H_ANG_HI)
      sw_mux = {12'h000, ang_ff[19:16]};
    else if (i_addr == pre_pkg::H_TURN_LO)
      sw_mux = turn_ff[15:0];
    else
      sw_mux = {{8{turn_ff[23]}}, turn_ff[23:16]};
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
      rdata_ff <= 16'h0000;
    else
      rdata_ff <= i_rd ? sw_mux : 16'h0000;
  end

  // outputs
  assign o_rdata      = rdata_ff;
  assign o_dev_irq    = link.irq;
  assign link.addr    = addr_ff;
  assign link.wdata   = wdata_ff;
  assign link.wr      = wr_ff;
  assign link.rd      = rd_ff;
  assign link.fe_wake = wake_ff;
endmodule

/* test/pre_link_properties.sv */
// checker: protocol of the link between controller and back end
// assumes all link signals are sampled on the rising edge of i_mclk
`timescale 1ns/1ps
module pre_link_properties (
  // clock and reset
  input wire logic        i_mclk,
  input wire logic        i_rst_b,
  // link signals
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        irq,
  input wire logic        fe_wake
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  // decoded strobes
  wire ka_wr = wr && addr == pre_pkg::REG_KA;
  wire ct_wr = wr && addr == pre_pkg::REG_CTRL;

  sequence s_kv_wr;
    wr && addr == pre_pkg::REG_KV;
  endsequence
  sequence s_ka_wr;
    ka_wr;
  endsequence

  property p_no_both;
    !(wr && rd);
  endproperty
  property p_rdata_idle;
    !$past(rd) |-> rdata == 16'h0000;
  endproperty
  property p_ang_hi;
    rd && addr == pre_pkg::REG_ANG_HI |=> rdata[15:4] == 12'h000;
  endproperty
  property p_turn_hi;
    rd && addr == pre_pkg::REG_TURN_HI |=> rdata[15:8] == {8{rdata[7]}};
  endproperty
  property p_stat_rsv;
    rd && addr == pre_pkg::REG_STAT |=> (rdata & 16'hdffe) == 16'h0000;
  endproperty
  property p_ctrl_fields;
    ct_wr |-> (wdata & 16'h4fff) == 16'h0000;
  endproperty
  property p_sleep_quiet;
    !fe_wake |-> !wr && !rd;
  endproperty
  // awake span of 20 and sleep span of 44 both exceed 8
  property p_wake_len;
    $rose(fe_wake) |-> fe_wake [*8];
  endproperty
  property p_sleep_len;
    $fell(fe_wake) |-> !fe_wake [*8];
  endproperty
  property p_poll_order;
    s_kv_wr ##1 fe_wake |-> ka_wr;
  endproperty
  property p_poll_ctrl;
    s_ka_wr ##1 fe_wake |-> ct_wr;
  endproperty

  a_no_both:     assert property (p_no_both) else $error("wr and rd together");
  a_rdata_idle:  assert property (p_rdata_idle) else $error("rdata not zero");
  a_ang_hi:      assert property (p_ang_hi) else $error("angle hi too wide");
  a_turn_hi:     assert property (p_turn_hi) else $error("turns not sign ext");
  a_stat_rsv:    assert property (p_stat_rsv) else $error("status spare bits");
  a_ctrl_fields: assert property (p_ctrl_fields) else $error("ctrl spare bits");
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("traffic asleep");
  a_wake_len:    assert property (p_wake_len) else $error("wake too short");
  a_sleep_len:   assert property (p_sleep_len) else $error("sleep too short");
  a_poll_order:  assert property (p_poll_order) else $error("poll order kv ka");
  a_poll_ctrl:   assert property (p_poll_ctrl) else $error("poll order ka ctrl");
endmodule

/* test/position_report_extrapolation_tb.sv */
// testbench: controller and back end joined over the link
// assumes 50 MHz clock and software access through the controller port
`timescale 1ns/1ps
module position_report_extrapolation_tb;
  // bench signals
  logic               i_mclk;
  logic               i_rst_b;
  logic               i_sample_vld;
  logic [19:0]        i_angle;
  logic signed [19:0] i_velocity;
  logic [7:0]         i_coil_open;
  logic [19:0]        o_angle;
  logic [23:0]        o_turns;
  logic [19:0]        o_velocity;
  logic [2:0]         i_addr;
  logic [15:0]        i_wdata;
  logic               i_wr;
  logic               i_rd;
  logic [15:0]        o_rdata;
  logic               i_battery_mode;
  logic               o_dev_irq;
  int                 miscompares;
  int                 checks;

  pre_link_if link_if ();
  pre_dev pre_dev_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_sample_vld(i_sample_vld),
    .i_angle(i_angle), .i_velocity(i_velocity), .i_coil_open(i_coil_open),
    .o_angle(o_angle), .o_turns(o_turns), .o_velocity(o_velocity), .link(link_if));
  // short wake period keeps battery mode quick
  pre_host #(.WAKE_PERIOD(64)) pre_host_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_battery_mode(i_battery_mode), .o_dev_irq(o_dev_irq), .link(link_if));
  pre_link_properties pre_link_properties_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .addr(link_if.addr), .wdata(link_if.wdata), .wr(link_if.wr), .rd(link_if.rd),
    .rdata(link_if.rdata), .irq(link_if.irq), .fe_wake(link_if.fe_wake));

  // clock
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic sw_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic sw_rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
  endtask

  task automatic wait_stat(input int b, input logic v, input int lim, output int n);
    logic [15:0] d;
    n = 0;
    do
    begin
      sw_rd(pre_pkg::H_STAT, d);
      n++;
    end
    while (d[b] !== v && n < lim);
  endtask

  task automatic smp(input logic [19:0] a, input logic [19:0] v);
    @(posedge i_mclk);
    i_sample_vld <= 1'b1;
    i_angle <= a;
    i_velocity <= v;
    @(posedge i_mclk);
    i_sample_vld <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask

  // startup test sees the open coil, then two tests on demand
  task automatic t_coil();
    int n;
    logic [15:0] d;
    wait_stat(1, 1'b1, 20, n);
    chk("startup_busy", 24'h1, n < 20);
    wait_stat(1, 1'b0, 60, n);
    sw_rd(pre_pkg::H_STAT, d);
    chk("startup_open", 24'h1, d[0]);
    for (int i = 0; i < 2; i++)
    begin
      i_coil_open <= (i == 0) ? 8'h00 : 8'h80;
      sw_wr(pre_pkg::H_CTRL, 16'h0004);
      wait_stat(1, 1'b1, 10, n);
      chk("test_start", 24'h1, n < 10);
      wait_stat(1, 1'b0, 60, n);
      chk("test_len", 24'h1, n >= 12 && n <= 40);
      sw_rd(pre_pkg::H_STAT, d);
      chk("open_flag", i[0], d[0]);
    end
  endtask

  // wraps in both directions, ending one turn below zero
  task automatic t_turns();
    logic [19:0] ang [6] = '{20'hffff0, 20'h00010, 20'hfffff, 20'h80000, 20'h00000, 20'hfffff};
    logic [23:0] trn [6] = '{24'h0, 24'h1, 24'h0, 24'h0, 24'h0, 24'hffffff};
    logic [15:0] d;
    for (int i = 0; i < 6; i++)
    begin
      smp(ang[i], 20'hbaadf);
      chk("angle", ang[i], o_angle);
      chk("turns", trn[i], o_turns);
    end
    chk("velocity", 20'hbaadf, o_velocity);
    repeat (12) @(posedge i_mclk);
    sw_rd(pre_pkg::H_TURN_HI, d);
    chk("turns_hi", 16'hffff, d);
    sw_rd(pre_pkg::H_TURN_LO, d);
    chk("turns_lo", 16'hffff, d);
    sw_rd(pre_pkg::H_ANG_HI, d);
    chk("angle_hi", 16'h000f, d);
  endtask

  // gain 0.25 on a steady velocity of 0x4000 adds about 0x1000
  task automatic t_extrap();
    logic [15:0] d;
    logic [19:0] diff;
    sw_wr(pre_pkg::H_CTRL, 16'h0001);
    repeat (12) @(posedge i_mclk);
    smp(20'h40000, 20'h04000);
    chk("no_coeff_raw", 20'h40000, o_angle);
    sw_wr(pre_pkg::H_KV, 16'h4000);
    sw_wr(pre_pkg::H_KA, 16'h0000);
    repeat (12) @(posedge i_mclk);
    repeat (40) smp(20'h40000, 20'h04000);
    diff = o_angle - 20'h40000;
    chk("extrap", 24'h1, diff >= 20'h00ff0 && diff <= 20'h01010);
    sw_rd(pre_pkg::H_STAT, d);
    chk("extrap_on", 24'h1, d[3]);
    sw_wr(pre_pkg::H_CTRL, 16'h0000);
    repeat (12) @(posedge i_mclk);
    smp(20'h40000, 20'h04000);
    chk("bypass", 20'h40000, o_angle);
  endtask

  // samples ignored asleep; 20 awake cycles in each 64
  task automatic t_battery();
    int n;
    n = 0;
    i_battery_mode <= 1'b1;
    while (link_if.fe_wake !== 1'b0 && n < 200)
    begin
      @(posedge i_mclk);
      n++;
    end
    smp(20'h12345, 20'h00000);
    chk("asleep_ignored", 20'h40000, o_angle);
    n = 0;
    repeat (64)
    begin
      @(negedge i_mclk);
      n += link_if.fe_wake;
    end
    chk("wake_len", 24'h000014, n[23:0]);
    // leave battery mode inside a wake span so no sleep span is cut short
    @(posedge link_if.fe_wake);
    i_battery_mode <= 1'b0;
  endtask

  // second reset with skip written before the startup wait ends
  task automatic t_skip();
    int n;
    i_rst_b <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    sw_wr(pre_pkg::H_CTRL, 16'h0002);
    wait_stat(1, 1'b1, 30, n);
    chk("startup_skipped", 24'h0, n < 30);
    chk("irq_masked", 24'h0, o_dev_irq);
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // main sequence; coil open from the start for the startup test
  initial
  begin
    miscompares = 0;
    checks = 0;
    i_rst_b = 1'b0;
    i_sample_vld = 1'b0;
    i_angle = 20'h00000;
    i_velocity = 20'h00000;
    i_coil_open = 8'h01;
    i_addr = 3'h0;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_battery_mode = 1'b0;
    repeat (16) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    t_coil();
    t_turns();
    t_extrap();
    t_battery();
    t_skip();
    wrap_up();
  end

  // watchdog: the run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    miscompares++;
    wrap_up();
  end
endmodule
